// ===== design/aux_clk_pkg.sv
// Shared constants, types and decoders for the auxiliary clock divider block.
// Assumes one system clock; divided and source clocks travel as one-cycle tick enables.
package aux_clk_pkg;

  localparam int NUM_AUX = 2;
  localparam int RATIO_W = 8;
  localparam int SEL_W   = 3;
  localparam int ADDR_W  = 12;

  // Source selector codes
  localparam logic [SEL_W-1:0] SRC_RC_OSC  = 3'h0;
  localparam logic [SEL_W-1:0] SRC_CRYSTAL = 3'h1;
  localparam logic [SEL_W-1:0] SRC_SDPLL = 3'h3;
  localparam logic [SEL_W-1:0] SEL_RESET = 3'h0;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] AUX_SEL_BASE   = 12'h000;
  localparam logic [ADDR_W-1:0] AUX_CFG_BASE   = 12'h010;
  localparam logic [ADDR_W-1:0] PIN_A_CFG      = 12'h020;
  localparam logic [ADDR_W-1:0] PIN_B_CFG      = 12'h024;
  localparam logic [ADDR_W-1:0] OUT_CHOICE     = 12'h028;
  localparam logic [ADDR_W-1:0] PENDING_FLAGS  = 12'h02C;
  localparam logic [ADDR_W-1:0] HANG_STATUS    = 12'h030;
  localparam logic [ADDR_W-1:0] WORD_STRIDE    = 12'h004;

  // Field positions
  localparam int GATE_BIT      = 31;
  localparam int RATIO_LSB     = 0;
  localparam int PIN_A_SEL_LSB = 0;
  localparam int PIN_B_SEL_LSB = 8;
  localparam int PEND_A_BIT    = 17;
  localparam int PEND_B_BIT    = 22;
  localparam int HANG_PIN_LSB  = 8;

  // Cycles a clock-output ratio, gate or source change stays pending
  localparam logic [3:0] UPD_CYCLES = 4'h4;

  // Ratio code that divides by two and carries the hang hazard
  localparam logic [RATIO_W-1:0] RATIO_DIV2 = 8'h01;

  typedef struct packed {
    logic               gate;
    logic [RATIO_W-1:0] ratio;
  } div_cfg_type;

  typedef struct packed {
    logic rc_osc;
    logic crystal;
    logic sdpll;
  } src_ticks_type;

  typedef enum logic [1:0] {
    TRACK_ST,
    HUNG_ST,
    AWAY_ST
  } recov_state_type;

  localparam div_cfg_type CFG_RESET = '{gate: 1'b0, ratio: 8'h00};

  function automatic logic pick_source(input logic [SEL_W-1:0] sel,
                                       input src_ticks_type    t);
    logic tick;
    tick = 1'b0;
    if (sel == SRC_RC_OSC) begin
      tick = t.rc_osc;
    end else if (sel == SRC_CRYSTAL) begin
      tick = t.crystal;
    end else if (sel == SRC_SDPLL) begin
      tick = t.sdpll;
    end
    return tick;
  endfunction : pick_source

  function automatic logic hazard_source(input logic [SEL_W-1:0] sel);
    return (sel == SRC_CRYSTAL) || (sel == SRC_SDPLL);
  endfunction : hazard_source

endpackage : aux_clk_pkg

// ===== design/clk_ratio_divider.sv
// Ratio divider with output gate and a stuck state for the divide-by-2 case.
// Assumes src_tick, hang_event and recover are on clk; rst is power-on reset.
`timescale 1ns/1ps
`default_nettype none
module clk_ratio_divider (
  // Clock and power-on reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Input clock and configuration
  input  wire logic                    src_tick,
  input  wire aux_clk_pkg::div_cfg_type cfg,
  // Hang control
  input  wire logic                    hang_event,
  input  wire logic                    recover,
  // Divided clock and state
  output var  logic                    out_tick,
  output var  logic                    stuck
);

  logic [aux_clk_pkg::RATIO_W-1:0] count;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count    <= '0;
      out_tick <= 1'b0;
    end else begin
      out_tick <= 1'b0;
      if (!cfg.gate || stuck) begin
        count <= '0;
      end else if (src_tick) begin
        if (count >= cfg.ratio) begin
          count    <= '0;
          out_tick <= 1'b1;
        end else begin
          count <= count + 8'h01;
        end
      end
    end
  end

  // Hang beats a recovery in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stuck <= 1'b0;
    end else if (hang_event && cfg.ratio == aux_clk_pkg::RATIO_DIV2) begin
      stuck <= 1'b1;
    end else if (recover) begin
      stuck <= 1'b0;
    end
  end

endmodule : clk_ratio_divider
`default_nettype wire

// ===== design/aux_source_mux.sv
// Auxiliary source selector and switch-away-and-back recovery detector.
// Assumes settled is high once the warm reset sequence has finished.
`timescale 1ns/1ps
`default_nettype none
module aux_source_mux (
  // Clock and power-on reset
  input  wire logic                            clk,
  input  wire logic                            rst,
  // Source ticks and selection
  input  wire aux_clk_pkg::src_ticks_type       ticks,
  input  wire logic [aux_clk_pkg::SEL_W-1:0]    sel,
  // Divider state and warm reset status
  input  wire logic                            stuck,
  input  wire logic                            settled,
  // Results
  output var  logic                            sel_tick,
  output var  logic                            recover
);

  aux_clk_pkg::recov_state_type state;
  logic [aux_clk_pkg::SEL_W-1:0] home;

  assign sel_tick = aux_clk_pkg::pick_source(sel, ticks);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state   <= aux_clk_pkg::TRACK_ST;
      home    <= aux_clk_pkg::SEL_RESET;
      recover <= 1'b0;
    end else begin
      recover <= 1'b0;
      unique case (state)
        aux_clk_pkg::TRACK_ST: begin
          home <= sel;
          if (stuck) begin
            state <= aux_clk_pkg::HUNG_ST;
          end
        end
        aux_clk_pkg::HUNG_ST: begin
          // Switching during the reset sequence does not count
          if (settled && sel != home) begin
            state <= aux_clk_pkg::AWAY_ST;
          end
        end
        aux_clk_pkg::AWAY_ST: begin
          if (settled && sel == home) begin
            recover <= 1'b1;
            state   <= aux_clk_pkg::TRACK_ST;
          end
        end
        default: begin
          state <= aux_clk_pkg::TRACK_ST;
        end
      endcase
    end
  end

endmodule : aux_source_mux
`default_nettype wire

// ===== design/aux_clock_divider_recovery.sv
// Auxiliary and clock-output dividers with source selection, APB registers,
// update-pending flags and the divide-by-2 hang, with recovery for the auxiliary dividers only.
// Assumes source ticks, glitch and reset events come from logic on clk.
// rst is the power-on reset; warm_reset marks a non-power-on reset sequence.
`timescale 1ns/1ps
`default_nettype none
module aux_clock_divider_recovery (
  // Clock and power-on reset
  input  wire logic                                  clk,
  input  wire logic                                  rst,
  // APB slave
  input  wire logic                                  psel,
  input  wire logic                                  penable,
  input  wire logic                                  pwrite,
  input  wire logic [aux_clk_pkg::ADDR_W-1:0]         paddr,
  input  wire logic [31:0]                           pwdata,
  output var  logic [31:0]                           prdata,
  output var  logic                                  pready,
  output var  logic                                  pslverr,
  // Source clock ticks
  input  wire aux_clk_pkg::src_ticks_type             source_ticks,
  // Disturbance events
  input  wire logic                                  crystal_glitch,
  input  wire logic                                  pll_glitch,
  input  wire logic                                  warm_reset,
  input  wire logic                                  phase_reset,
  // Divided clocks
  output var  logic [aux_clk_pkg::NUM_AUX-1:0]        aux_clock_tick,
  output var  logic                                  clock_output_pin_a,
  output var  logic                                  clock_output_pin_b
);

  // Register state
  logic [aux_clk_pkg::SEL_W-1:0] aux_source_select [aux_clk_pkg::NUM_AUX];
  aux_clk_pkg::div_cfg_type      aux_divider_config [aux_clk_pkg::NUM_AUX];
  aux_clk_pkg::div_cfg_type      pin_divider_config [2];
  logic [1:0]                    clock_output_source_choice [2];
  logic [3:0]                    pend_count [2];
  logic [1:0]                    divider_update_pending_flags;

  // Event and status wiring
  logic                          warm_reset_q;
  logic                          warm_rise;
  logic                          access_done;
  logic                          write_done;
  logic [aux_clk_pkg::NUM_AUX-1:0] aux_stuck;
  logic [aux_clk_pkg::NUM_AUX-1:0] aux_tick_w;
  logic [1:0]                    pin_stuck;
  logic [1:0]                    pin_tick_w;
  logic [1:0]                    pin_cfg_write;
  logic [1:0]                    choice_change;
  logic [1:0]                    next_choice [2];
  logic [31:0]                   read_word;
  logic                          addr_hit;

  assign access_done = psel && penable && pready;
  assign write_done  = access_done && pwrite && addr_hit;
  assign warm_rise   = warm_reset && !warm_reset_q;

  function automatic logic is_aux_sel(input logic [aux_clk_pkg::ADDR_W-1:0] a,
                                      input int idx);
    return a == aux_clk_pkg::AUX_SEL_BASE
                + aux_clk_pkg::WORD_STRIDE * idx[aux_clk_pkg::ADDR_W-1:0];
  endfunction : is_aux_sel

  function automatic logic is_aux_cfg(input logic [aux_clk_pkg::ADDR_W-1:0] a,
                                      input int idx);
    return a == aux_clk_pkg::AUX_CFG_BASE
                + aux_clk_pkg::WORD_STRIDE * idx[aux_clk_pkg::ADDR_W-1:0];
  endfunction : is_aux_cfg

  function automatic logic [31:0] cfg_word(input aux_clk_pkg::div_cfg_type c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[aux_clk_pkg::GATE_BIT] = c.gate;
    w[aux_clk_pkg::RATIO_LSB +: aux_clk_pkg::RATIO_W] = c.ratio;
    return w;
  endfunction : cfg_word

  function automatic aux_clk_pkg::div_cfg_type word_cfg(input logic [31:0] w);
    aux_clk_pkg::div_cfg_type c;
    c.gate  = w[aux_clk_pkg::GATE_BIT];
    c.ratio = w[aux_clk_pkg::RATIO_LSB +: aux_clk_pkg::RATIO_W];
    return c;
  endfunction : word_cfg

  // Address decode and read mux
  always_comb begin
    addr_hit  = 1'b0;
    read_word = 32'h0000_0000;
    for (int i = 0; i < aux_clk_pkg::NUM_AUX; i++) begin
      if (is_aux_sel(paddr, i)) begin
        addr_hit = 1'b1;
        read_word[aux_clk_pkg::SEL_W-1:0] = aux_source_select[i];
      end
      if (is_aux_cfg(paddr, i)) begin
        addr_hit  = 1'b1;
        read_word = cfg_word(aux_divider_config[i]);
      end
    end
    if (paddr == aux_clk_pkg::PIN_A_CFG) begin
      addr_hit  = 1'b1;
      read_word = cfg_word(pin_divider_config[0]);
    end
    if (paddr == aux_clk_pkg::PIN_B_CFG) begin
      addr_hit  = 1'b1;
      read_word = cfg_word(pin_divider_config[1]);
    end
    if (paddr == aux_clk_pkg::OUT_CHOICE) begin
      addr_hit = 1'b1;
      read_word[aux_clk_pkg::PIN_A_SEL_LSB +: 2] = clock_output_source_choice[0];
      read_word[aux_clk_pkg::PIN_B_SEL_LSB +: 2] = clock_output_source_choice[1];
    end
    if (paddr == aux_clk_pkg::PENDING_FLAGS) begin
      addr_hit = 1'b1;
      read_word[aux_clk_pkg::PEND_A_BIT] = divider_update_pending_flags[0];
      read_word[aux_clk_pkg::PEND_B_BIT] = divider_update_pending_flags[1];
    end
    if (paddr == aux_clk_pkg::HANG_STATUS) begin
      addr_hit = 1'b1;
      read_word[aux_clk_pkg::NUM_AUX-1:0] = aux_stuck;
      read_word[aux_clk_pkg::HANG_PIN_LSB +: 2] = pin_stuck;
    end
  end

  // APB handshake: one wait state, answer registered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      if (psel && penable && !pready) begin
        pready  <= 1'b1;
        pslverr <= !addr_hit;
        prdata  <= (pwrite || !addr_hit) ? 32'h0000_0000 : read_word;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      warm_reset_q <= 1'b0;
    end else begin
      warm_reset_q <= warm_reset;
    end
  end

  // Auxiliary selection and configuration registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < aux_clk_pkg::NUM_AUX; i++) begin
        aux_source_select[i]  <= aux_clk_pkg::SEL_RESET;
        aux_divider_config[i] <= aux_clk_pkg::CFG_RESET;
      end
    end else if (write_done) begin
      for (int i = 0; i < aux_clk_pkg::NUM_AUX; i++) begin
        if (is_aux_sel(paddr, i)) begin
          aux_source_select[i] <= pwdata[aux_clk_pkg::SEL_W-1:0];
        end
        if (is_aux_cfg(paddr, i)) begin
          aux_divider_config[i] <= word_cfg(pwdata);
        end
      end
    end
  end

  assign pin_cfg_write[0] = write_done && paddr == aux_clk_pkg::PIN_A_CFG;
  assign pin_cfg_write[1] = write_done && paddr == aux_clk_pkg::PIN_B_CFG;
  assign next_choice[0]   = pwdata[aux_clk_pkg::PIN_A_SEL_LSB +: 2];
  assign next_choice[1]   = pwdata[aux_clk_pkg::PIN_B_SEL_LSB +: 2];

  // Clock-output configuration and source choice
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 2; i++) begin
        pin_divider_config[i]         <= aux_clk_pkg::CFG_RESET;
        clock_output_source_choice[i] <= aux_clk_pkg::SEL_RESET[1:0];
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (pin_cfg_write[i]) begin
          pin_divider_config[i] <= word_cfg(pwdata);
        end
        if (write_done && paddr == aux_clk_pkg::OUT_CHOICE) begin
          clock_output_source_choice[i] <= next_choice[i];
        end
      end
    end
  end

  // Auxiliary dividers
  for (genvar g = 0; g < aux_clk_pkg::NUM_AUX; g++) begin : g_aux
    logic sel_tick;
    logic recover;
    logic glitch_hit;
    logic hang_event;

    assign glitch_hit = (aux_source_select[g] == aux_clk_pkg::SRC_CRYSTAL && crystal_glitch)
                     || (aux_source_select[g] == aux_clk_pkg::SRC_SDPLL && pll_glitch);
    // Only crystal or PLL fed dividers are exposed
    assign hang_event = aux_clk_pkg::hazard_source(aux_source_select[g])
                        && (glitch_hit || warm_rise);

    aux_source_mux u_mux (
      .clk      (clk),
      .rst      (rst),
      .ticks    (source_ticks),
      .sel      (aux_source_select[g]),
      .stuck    (aux_stuck[g]),
      .settled  (!warm_reset),
      .sel_tick (sel_tick),
      .recover  (recover)
    );

    clk_ratio_divider u_div (
      .clk        (clk),
      .rst        (rst),
      .src_tick   (sel_tick),
      .cfg        (aux_divider_config[g]),
      .hang_event (hang_event),
      .recover    (recover),
      .out_tick   (aux_tick_w[g]),
      .stuck      (aux_stuck[g])
    );
  end

  // Clock-output dividers
  for (genvar g = 0; g < 2; g++) begin : g_pin
    logic sel_tick;
    logic hang_event;

    assign choice_change[g] = write_done && paddr == aux_clk_pkg::OUT_CHOICE
                              && next_choice[g] != clock_output_source_choice[g];
    assign sel_tick = aux_clk_pkg::pick_source({1'b0, clock_output_source_choice[g]},
                                               source_ticks);
    // Gated-off divider is immune to a source change
    assign hang_event = pin_divider_config[g].gate
                        && (choice_change[g] || phase_reset);

    clk_ratio_divider u_div (
      .clk        (clk),
      .rst        (rst),
      .src_tick   (sel_tick),
      .cfg        (pin_divider_config[g]),
      .hang_event (hang_event),
      .recover    (1'b0),
      .out_tick   (pin_tick_w[g]),
      .stuck      (pin_stuck[g])
    );

    // New write restarts the pending window
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        pend_count[g] <= 4'h0;
      end else if (pin_cfg_write[g] || choice_change[g]) begin
        pend_count[g] <= aux_clk_pkg::UPD_CYCLES;
      end else if (pend_count[g] != 4'h0) begin
        pend_count[g] <= pend_count[g] - 4'h1;
      end
    end

    assign divider_update_pending_flags[g] = pend_count[g] != 4'h0;
  end

  assign aux_clock_tick     = aux_tick_w;
  assign clock_output_pin_a = pin_tick_w[0];
  assign clock_output_pin_b = pin_tick_w[1];

endmodule : aux_clock_divider_recovery
`default_nettype wire

// ===== sim/aux_clk_asserts.sv
// Checker on the top-level ports of the divider block.
// Assumes APB with one wait state and divided ticks from flops.
`timescale 1ns/1ps
`default_nettype none
module aux_clk_asserts (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // Bus
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                prdata,
  input  wire logic                       pready,
  input  wire logic                       pslverr,
  // Clocks
  input  wire aux_clk_pkg::src_ticks_type source_ticks,
  input  wire logic [1:0]                 aux_clock_tick,
  input  wire logic                       clock_output_pin_a,
  input  wire logic                       clock_output_pin_b
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_access;
    psel && penable && !pready;
  endsequence

  a_ready_answer: assert property (s_access |=> pready)
    else $error("no ready after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("ready without access");
  a_err_quiet: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error response malformed");
  a_write_no_data: assert property (pready && $past(pwrite) |-> prdata == 32'h0000_0000)
    else $error("read data on a write");
  a_aux_needs_src: assert property (|aux_clock_tick |-> $past(|source_ticks))
    else $error("aux tick without source tick");
  a_pin_needs_src: assert property (clock_output_pin_a || clock_output_pin_b |->
                                    $past(|source_ticks))
    else $error("pin tick without source tick");
  a_reset_quiet: assert property ($past(rst) |-> !pready && aux_clock_tick == 2'b00
                                  && !clock_output_pin_a && !clock_output_pin_b)
    else $error("output active after reset");
endmodule : aux_clk_asserts

bind aux_clock_divider_recovery aux_clk_asserts i_aux_clk_asserts (
  .clk, .rst, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
  .source_ticks, .aux_clock_tick, .clock_output_pin_a, .clock_output_pin_b);
`default_nettype wire

// ===== sim/tick_sink.sv
// Consumer model: counts divided ticks per output since the last clear.
// Assumes ticks are one-cycle pulses on clk.
`timescale 1ns/1ps
`default_nettype none
module tick_sink (
  // Clock, reset and window restart
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            clr,
  // Divided clocks
  input  wire logic [1:0]      aux_tick,
  input  wire logic            pin_a,
  input  wire logic            pin_b,
  // Counts: pin_b, pin_a, aux1, aux0
  output var  logic [3:0][7:0] seen
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seen <= '0;
    end else if (clr) begin
      seen <= '0;
    end else begin
      seen[0] <= seen[0] + {7'h00, aux_tick[0]};
      seen[1] <= seen[1] + {7'h00, aux_tick[1]};
      seen[2] <= seen[2] + {7'h00, pin_a};
      seen[3] <= seen[3] + {7'h00, pin_b};
    end
  end
endmodule : tick_sink
`default_nettype wire

// ===== sim/tb_top.sv
// Self-checking bench: APB master, source tick maker and disturbance pulses.
// Source rates: internal RC every cycle, crystal every 2nd, PLL every 4th.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                       clk, rst, psel, penable, pwrite, pready, pslverr, clr;
  logic [11:0]                paddr;
  logic [31:0]                pwdata, prdata;
  aux_clk_pkg::src_ticks_type source_ticks;
  logic                       crystal_glitch, pll_glitch, warm_reset, phase_reset;
  logic [1:0]                 aux_clock_tick;
  logic                       clock_output_pin_a, clock_output_pin_b;
  logic [3:0][7:0]            seen;
  logic [7:0]                 cyc;
  int                         bad_count, checks_done, cycles;

  aux_clock_divider_recovery i_aux_clock_divider_recovery (.clk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .source_ticks, .crystal_glitch,
    .pll_glitch, .warm_reset, .phase_reset, .aux_clock_tick, .clock_output_pin_a,
    .clock_output_pin_b);
  tick_sink i_tick_sink (.clk, .rst, .clr, .aux_tick(aux_clock_tick),
    .pin_a(clock_output_pin_a), .pin_b(clock_output_pin_b), .seen);

  always #50 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 8'h01;
    source_ticks <= '{rc_osc: 1'b1, crystal: cyc[0], sdpll: cyc[1:0] == 2'b00};
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles > 5000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Look between edges: the value seen is what the next edge samples
    @(negedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (n >= 20) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    end
    q = prdata;
    e = pslverr;
    @(posedge clk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    check(q, exp);
  endtask : rd

  task automatic set_sel(input int i, input logic [31:0] d);
    wr(aux_clk_pkg::AUX_SEL_BASE + 12'(4 * i), d);
  endtask : set_sel

  task automatic set_aux(input int i, input logic [31:0] d);
    wr(aux_clk_pkg::AUX_CFG_BASE + 12'(4 * i), d);
  endtask : set_aux

  // Window is a multiple of every divided period, so phase never matters
  task automatic count(input int n, input logic [31:0] exp);
    repeat (8) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (n) @(posedge clk);
    @(negedge clk);
    check(seen, exp);
    @(posedge clk);
  endtask : count

  task automatic settle(input int b);
    logic [31:0] q;
    logic        e;
    int          n;
    n = 0;
    q = 32'hffff_ffff;
    while (q[b] !== 1'b0 && n < 10) begin
      apb(1'b0, aux_clk_pkg::PENDING_FLAGS, 32'h0000_0000, q, e);
      n++;
    end
    check({31'h0, q[b]}, 32'h0000_0000);
  endtask : settle

  task automatic t_regs;
    logic [31:0] q;
    logic        e;
    rd(aux_clk_pkg::AUX_SEL_BASE + 12'h004, 32'h0000_0000);
    rd(aux_clk_pkg::PIN_A_CFG, 32'h0000_0000);
    rd(aux_clk_pkg::PENDING_FLAGS, 32'h0000_0000);
    apb(1'b0, 12'h100, 32'h0000_0000, q, e);
    check({31'h0, e}, 32'h0000_0001);
  endtask : t_regs

  task automatic t_select;
    logic [31:0] codes [4] = '{32'h0, 32'h1, 32'h3, 32'h2};
    logic [31:0] rate [4] = '{32'h10, 32'h08, 32'h04, 32'h00};
    set_aux(0, 32'h8000_0000);
    for (int k = 0; k < 4; k++) begin
      set_sel(0, codes[k]);
      count(16, rate[k]);
    end
    set_aux(0, 32'h0000_0000);
    count(16, 32'h0000_0000);
  endtask : t_select

  task automatic t_aux_hang;
    set_sel(0, 32'h1);
    set_sel(1, 32'h1);
    set_aux(0, 32'h8000_0002);
    set_aux(1, 32'h8000_0001);
    count(24, 32'h0000_0604);
    crystal_glitch <= 1'b1;
    @(posedge clk);
    crystal_glitch <= 1'b0;
    count(24, 32'h0000_0004);
    warm_reset <= 1'b1;
    count(24, 32'h0000_0004);
    warm_reset <= 1'b0;
    set_aux(1, 32'h0000_0001);
    set_sel(1, 32'h0);
    set_sel(1, 32'h1);
    set_aux(1, 32'h8000_0000);
    set_aux(1, 32'h8000_0001);
    count(24, 32'h0000_0604);
    set_sel(0, 32'h3);
    set_aux(0, 32'h8000_0001);
    pll_glitch <= 1'b1;
    @(posedge clk);
    pll_glitch <= 1'b0;
    count(24, 32'h0000_0600);
  endtask : t_aux_hang

  task automatic t_pins;
    wr(aux_clk_pkg::PIN_A_CFG, 32'h8000_0001);
    settle(17);
    wr(aux_clk_pkg::PIN_B_CFG, 32'h8000_0002);
    rd(aux_clk_pkg::PENDING_FLAGS, 32'h0040_0000);
    settle(22);
    count(24, 32'h080c_0600);
    wr(aux_clk_pkg::PIN_B_CFG, 32'h0000_0002);
    settle(22);
    wr(aux_clk_pkg::OUT_CHOICE, 32'h0000_0300);
    settle(22);
    wr(aux_clk_pkg::PIN_B_CFG, 32'h8000_0002);
    settle(22);
    wr(aux_clk_pkg::PIN_B_CFG, 32'h8000_0001);
    settle(22);
    count(24, 32'h030c_0600);
    wr(aux_clk_pkg::OUT_CHOICE, 32'h0000_0301);
    wr(aux_clk_pkg::OUT_CHOICE, 32'h0000_0300);
    count(24, 32'h0300_0600);
    phase_reset <= 1'b1;
    @(posedge clk);
    phase_reset <= 1'b0;
    count(24, 32'h0000_0600);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(aux_clk_pkg::AUX_SEL_BASE + 12'h004, 32'h0000_0000);
    rd(aux_clk_pkg::OUT_CHOICE, 32'h0000_0000);
    wr(aux_clk_pkg::PIN_A_CFG, 32'h8000_0001);
    count(24, 32'h000c_0000);
  endtask : t_pins

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {psel, penable, pwrite, clr} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    source_ticks = '0;
    {crystal_glitch, pll_glitch, warm_reset, phase_reset} = 4'h0;
    cyc = 8'h00;
    bad_count = 0;
    checks_done = 0;
    cycles = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_select();
    t_aux_hang();
    t_pins();
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
